// >>> pbw_regs.vh
`ifndef PBW_REGS_VH
`define PBW_REGS_VH

`define PBW_CLK_HZ          10000000
`define PBW_TICK_US         1000
`define PBW_TICK_CYC        ((`PBW_CLK_HZ / 1000000) * `PBW_TICK_US)
`define PBW_DB_MS           12'h00f
`define PBW_GAP_MS          2
`define PBW_SLOW_MS         12'h0fa
`define PBW_FAST_MS         12'h032
`define PBW_FAST_AFTER_MS   12'h3e8
`define PBW_IDLE_MS         12'h7d0
`define PBW_SHDN_MS         12'h7d0
`define PBW_EXIT_RPT_MS     12'h0fa
`define PBW_WIPER_W         5
`define PBW_WIPER_MAX       5'h1f
`define PBW_WIPER_MIN       5'h00
`define PBW_NV_RESET        5'h10
`define PBW_MS_W            12

`endif

// >>> pbw_nvm.v
`timescale 1ns/1ps
module pbw_nvm #(
	parameter WIDTH    = 5,
	parameter INIT_VAL = 5'h10,
	parameter WR_CYC   = 16
) (
	input  wire             ref_clk_i,  // clock
	input  wire             rst_i,      // sync reset, active high
	input  wire             wr_i,       // write request pulse
	input  wire [WIDTH-1:0] wr_data_i,  // value to save
	output reg  [WIDTH-1:0] rd_data_o,  // stored value, registered
	output wire             busy_o      // write cycle in progress
);
	// the cell survives rst_i: it models the non-volatile store
	reg [WIDTH-1:0] cell_q = INIT_VAL;
	reg [15:0]      wcnt_q;

	assign busy_o = (wcnt_q != 16'h0000);

	always @(posedge ref_clk_i)
	begin
		if (wr_i && !busy_o)
			cell_q <= wr_data_i;
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			wcnt_q <= 16'h0000;
		else if (wr_i && !busy_o)
			wcnt_q <= WR_CYC[15:0];
		else if (busy_o)
			wcnt_q <= wcnt_q - 16'h0001;
		rd_data_o <= cell_q;
	end
endmodule // pbw_nvm

// >>> pbw_wiper_ctrl.v
`timescale 1ns/1ps
`include "pbw_regs.vh"

// Summary of operation
// - store mode pin low at reset enables idle save for the session.
// - pin high at reset: manual save on each valid rising edge.
// - 5-bit wiper counter stepped by buttons, decoded one-hot to 32 taps.
// - presses shorter than the debounce interval change nothing.
// - one press gives one step; held press repeats steps.
// - first second of a held press repeats at slow rate.
// - after one second the repeat switches to the fast rate.
// - release stops stepping at once and returns to standby.
// - multi-button presses are discarded, except shutdown entry.
// - counter saturates at both ends, never wraps.
// - idle save writes the counter after 2 s with no step activity.
// - at reset the stored value is recalled into the counter.
// - manual mode: pin held low blocks step inputs until released high.
// - inputs are ignored during a non-volatile write.
// - both buttons low 2 s enters shutdown, wiper at bottom tap.
// - both buttons must fall within one debounce window, else ignore.
// - any input low over 15 ms leaves shutdown, restoring the wiper.
// - button held beyond 250 ms on exit starts auto-repeat.
// - slow scan steps spaced 250 ms.
// - fast scan steps spaced 50 ms.
module pbw_wiper_ctrl #(
	parameter TICK_CYC = `PBW_TICK_CYC,
	parameter NV_WR_CYC = 16
) (
	input  wire        ref_clk_i,       // 10 MHz clock
	input  wire        rst_i,           // power-up reset, sync, active high
	input  wire        step_up_n_i,     // step up button, active low
	input  wire        step_down_n_i,   // step down button, active low
	input  wire        store_mode_n_i,  // store mode pin, active low
	output reg  [4:0]  wiper_code_o,    // wiper counter as driven to the decoder
	output reg  [31:0] tap_sel_o,       // one-hot tap switch select
	output reg         top_connect_o,   // array connected to top terminal
	output reg         shutdown_o,      // shutdown mode active
	output reg         idle_save_o,     // idle save enabled
	output wire        nv_busy_o        // non-volatile write in progress
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_PRESS = 5'h02;
	localparam [4:0] ST_MULTI = 5'h04;
	localparam [4:0] ST_SHDN = 5'h08;
	localparam [4:0] ST_EXIT = 5'h10;

	localparam [11:0] DB_MS = `PBW_DB_MS;
	localparam [11:0] SLOW_MS = `PBW_SLOW_MS;
	localparam [11:0] FAST_MS = `PBW_FAST_MS;
	localparam [11:0] FAST_AFTER_MS = `PBW_FAST_AFTER_MS;
	localparam [11:0] IDLE_MS = `PBW_IDLE_MS;
	localparam [11:0] SHDN_MS = `PBW_SHDN_MS;
	localparam [11:0] EXIT_RPT_MS = `PBW_EXIT_RPT_MS;

	function [4:0] step_sat;
		input [4:0] v;
		input       up;
		begin
			if (up)
				step_sat = (v == `PBW_WIPER_MAX) ? v : v + 5'h01;
			else
				step_sat = (v == `PBW_WIPER_MIN) ? v : v - 5'h01;
		end
	endfunction

	function [11:0] ms_inc;
		input [11:0] v;
		begin
			ms_inc = (v == 12'hfff) ? v : v + 12'h001;
		end
	endfunction

	// two-stage synchronisers for the three pins
	reg [2:0]  sync1_q;
	reg [2:0]  sync2_q;
	reg [15:0] pre_q;
	reg        tick_q;
	reg [11:0] up_ms_q;
	reg [11:0] dn_ms_q;
	reg [11:0] sm_ms_q;
	reg        up_db_q;
	reg        dn_db_q;
	reg        sm_db_q;
	reg        sm_db_prev_q;
	reg        started_q;
	reg        recall_q;
	reg        idle_en_q;
	reg [4:0]  state_q;
	reg [4:0]  cnt_q;
	reg [4:0]  hold_q;
	reg        dir_up_q;
	reg [11:0] press_ms_q;
	reg [11:0] rpt_ms_q;
	reg [11:0] idle_ms_q;
	reg        dirty_q;
	reg        nv_wr_q;
	reg        sm_blocked_q;
	reg        no_shdn_q;
	wire [4:0] nv_rd;
	wire       nv_busy;
	wire       up_raw;
	wire       dn_raw;
	wire       sm_raw;
	wire       any_step;
	wire       in_ok;
	wire       man_save;

	pbw_nvm #(
		.WIDTH    (5),
		.INIT_VAL (`PBW_NV_RESET),
		.WR_CYC   (NV_WR_CYC)
	) u_nvm (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_i      (nv_wr_q),
		.wr_data_i (cnt_q),
		.rd_data_o (nv_rd),
		.busy_o    (nv_busy)
	);

	assign nv_busy_o = nv_busy;
	assign up_raw = ~sync2_q[0];
	assign dn_raw = ~sync2_q[1];
	assign sm_raw = ~sync2_q[2];
	assign any_step = up_db_q | dn_db_q;
	assign in_ok = !nv_busy && !nv_wr_q && started_q;
	assign man_save = !idle_en_q && sm_db_prev_q && !sm_db_q && in_ok;

	// no reset here: the mode pin level must reach the strap capture while reset is still held
	always @(posedge ref_clk_i)
	begin
		sync1_q <= {store_mode_n_i, step_down_n_i, step_up_n_i};
		sync2_q <= sync1_q;
	end

	// millisecond tick shared by every interval counter
	always @(posedge ref_clk_i)
	begin
		if (rst_i || pre_q == TICK_CYC[15:0] - 16'h0001)
			pre_q <= 16'h0000;
		else
			pre_q <= pre_q + 16'h0001;
		tick_q <= !rst_i && (pre_q == TICK_CYC[15:0] - 16'h0001);
	end

	// low-time counters restart whenever the pin goes high
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			up_ms_q <= 12'h000;
			dn_ms_q <= 12'h000;
			sm_ms_q <= 12'h000;
			up_db_q <= 1'b0;
			dn_db_q <= 1'b0;
			sm_db_q <= 1'b0;
			sm_db_prev_q <= 1'b0;
		end
		else
		begin
			up_ms_q <= !up_raw ? 12'h000 : (tick_q ? ms_inc(up_ms_q) : up_ms_q);
			dn_ms_q <= !dn_raw ? 12'h000 : (tick_q ? ms_inc(dn_ms_q) : dn_ms_q);
			sm_ms_q <= !sm_raw ? 12'h000 : (tick_q ? ms_inc(sm_ms_q) : sm_ms_q);
			up_db_q <= up_raw && (up_ms_q >= DB_MS);
			dn_db_q <= dn_raw && (dn_ms_q >= DB_MS);
			sm_db_q <= sm_raw && (sm_ms_q >= DB_MS);
			sm_db_prev_q <= sm_db_q;
		end
	end

	// strap capture and recall one cycle after reset release, when the pipe is valid
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			started_q <= 1'b0;
			recall_q <= 1'b0;
			idle_en_q <= 1'b0;
		end
		else
		begin
			recall_q <= 1'b1;
			if (recall_q && !started_q)
			begin
				started_q <= 1'b1;
				idle_en_q <= sm_raw;
			end
		end
	end

	// manual mode: a low level on the pin locks out stepping until it is high again
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			sm_blocked_q <= 1'b0;
		else
			sm_blocked_q <= !idle_en_q && started_q && sm_raw;
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			cnt_q <= `PBW_NV_RESET;
			hold_q <= `PBW_NV_RESET;
			dir_up_q <= 1'b1;
			press_ms_q <= 12'h000;
			rpt_ms_q <= 12'h000;
			idle_ms_q <= 12'h000;
			dirty_q <= 1'b0;
			nv_wr_q <= 1'b0;
			no_shdn_q <= 1'b0;
		end
		else
		begin
			nv_wr_q <= 1'b0;
			if (recall_q && !started_q)
				cnt_q <= nv_rd;
			if (tick_q)
			begin
				press_ms_q <= ms_inc(press_ms_q);
				rpt_ms_q <= ms_inc(rpt_ms_q);
			end
			// idle timer restarts on any step input activity
			if (up_raw || dn_raw || state_q != ST_IDLE)
				idle_ms_q <= 12'h000;
			else if (tick_q)
				idle_ms_q <= ms_inc(idle_ms_q);
			if (in_ok && idle_en_q && dirty_q && idle_ms_q >= IDLE_MS)
			begin
				nv_wr_q <= 1'b1;
				dirty_q <= 1'b0;
			end
			else if (man_save)
			begin
				nv_wr_q <= 1'b1;
				dirty_q <= 1'b0;
			end
			if (in_ok)
			begin
				case (state_q)
					ST_IDLE:
					begin
						if (!sm_blocked_q && up_db_q && dn_db_q)
						begin
							state_q <= ST_MULTI;
							press_ms_q <= 12'h000;
							no_shdn_q <= 1'b0;
						end
						else if (!sm_blocked_q && (up_raw && dn_raw))
						begin
							// second button may still be inside its debounce window
							state_q <= ST_IDLE;
						end
						else if (!sm_blocked_q && (up_db_q || dn_db_q))
						begin
							state_q <= ST_PRESS;
							dir_up_q <= up_db_q;
							cnt_q <= step_sat(cnt_q, up_db_q);
							dirty_q <= 1'b1;
							press_ms_q <= DB_MS;
							rpt_ms_q <= 12'h000;
						end
					end
					ST_PRESS:
					begin
						if (!(dir_up_q ? up_raw : dn_raw))
							state_q <= ST_IDLE;
						else if (sm_blocked_q)
							state_q <= ST_IDLE;
						else if (dir_up_q ? dn_raw : up_raw)
						begin
							// second button fell after the first had debounced: too late for shutdown
							state_q <= ST_MULTI;
							no_shdn_q <= 1'b1;
						end
						else if (rpt_ms_q >= ((press_ms_q > FAST_AFTER_MS) ? FAST_MS : SLOW_MS))
						begin
							cnt_q <= step_sat(cnt_q, dir_up_q);
							dirty_q <= 1'b1;
							rpt_ms_q <= 12'h000;
						end
					end
					ST_MULTI:
					begin
						if (!up_raw && !dn_raw)
							state_q <= ST_IDLE;
						else if (up_db_q && dn_db_q && !no_shdn_q && press_ms_q >= SHDN_MS)
						begin
							state_q <= ST_SHDN;
							hold_q <= cnt_q;
						end
						else if (!(up_db_q && dn_db_q))
							press_ms_q <= 12'h000;
					end
					ST_SHDN:
					begin
						// must see a release first, else the entry press would exit at once
						if (!up_raw && !dn_raw && !sm_raw)
							state_q <= ST_EXIT;
					end
					ST_EXIT:
					begin
						if (up_db_q || dn_db_q || sm_db_q)
						begin
							cnt_q <= hold_q;
							if (up_db_q ^ dn_db_q)
							begin
								state_q <= ST_PRESS;
								dir_up_q <= up_db_q;
								press_ms_q <= DB_MS;
								rpt_ms_q <= DB_MS - SLOW_MS + EXIT_RPT_MS;
							end
							else
							begin
								state_q <= ST_MULTI;
								no_shdn_q <= 1'b1;
							end
						end
					end
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wiper_code_o <= `PBW_WIPER_MIN;
			tap_sel_o <= 32'h00000001;
			top_connect_o <= 1'b1;
			shutdown_o <= 1'b0;
			idle_save_o <= 1'b0;
		end
		else
		begin
			shutdown_o <= (state_q == ST_SHDN) || (state_q == ST_EXIT);
			top_connect_o <= !((state_q == ST_SHDN) || (state_q == ST_EXIT));
			wiper_code_o <= ((state_q == ST_SHDN) || (state_q == ST_EXIT)) ? `PBW_WIPER_MIN : cnt_q;
			tap_sel_o <= 32'h00000001 << (((state_q == ST_SHDN) || (state_q == ST_EXIT)) ? 5'h00 : cnt_q);
			idle_save_o <= idle_en_q;
		end
	end
endmodule // pbw_wiper_ctrl

// >>> pbw_button_model.sv
`timescale 1ns/1ps
module pbw_button_model (
	input  wire up_press_i,    // hold up
	input  wire dn_press_i,    // hold down
	input  wire store_press_i, // hold store
	output wire step_up_n_o,   // up pin
	output wire step_down_n_o, // down pin
	output wire store_mode_n_o // mode pin
);
	// a switch to ground; released lines return high through the pull-up
	assign step_up_n_o    = up_press_i ? 1'b0 : 1'b1;
	assign step_down_n_o  = dn_press_i ? 1'b0 : 1'b1;
	assign store_mode_n_o = store_press_i ? 1'b0 : 1'b1;
endmodule // pbw_button_model

// >>> pbw_wiper_ctrl_sva.sv
`timescale 1ns/1ps
module pbw_wiper_ctrl_sva #(
	parameter TICK_CYC = 10
) (
	input wire        ref_clk_i,      // clock
	input wire        rst_i,          // reset
	input wire        step_up_n_i,    // up pin
	input wire        step_down_n_i,  // down pin
	input wire        store_mode_n_i, // mode pin
	input wire [4:0]  wiper_code_o,   // wiper
	input wire [31:0] tap_sel_o,      // taps
	input wire        top_connect_o,  // top tie
	input wire        shutdown_o,     // shutdown
	input wire        idle_save_o,    // idle mode
	input wire        nv_busy_o       // nv write
);
	reg [2:0]  settle_q;
	reg [31:0] up_low_q;
	reg [31:0] dn_low_q;
	always @(posedge ref_clk_i)
	begin
		settle_q <= rst_i ? 3'h0 : settle_q + {2'h0, ~&settle_q};
		up_low_q <= step_up_n_i ? 32'h0 : up_low_q + {31'h0, ~&up_low_q};
		dn_low_q <= step_down_n_i ? 32'h0 : dn_low_q + {31'h0, ~&dn_low_q};
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// recall and shutdown restore may jump, so steps are judged only away from them
	sequence s_awake;
		settle_q == 3'h7 && !shutdown_o && !$past(shutdown_o) && !$past(shutdown_o, 2);
	endsequence
	sequence s_inc;
		wiper_code_o == $past(wiper_code_o) + 5'h1 && wiper_code_o != 5'h0;
	endsequence
	sequence s_dec;
		wiper_code_o == $past(wiper_code_o) - 5'h1 && wiper_code_o != 5'h1f;
	endsequence
	sequence s_write;
		nv_busy_o [*8];
	endsequence
	property p_onehot; tap_sel_o == (32'h1 << wiper_code_o); endproperty
	property p_up_db; s_awake ##0 s_inc |-> up_low_q >= 13 * TICK_CYC; endproperty
	property p_dn_db; s_awake ##0 s_dec |-> dn_low_q >= 13 * TICK_CYC; endproperty
	property p_one_tap;
		s_awake ##0 $changed(wiper_code_o) |->
			wiper_code_o == $past(wiper_code_o) + 5'h1 || wiper_code_o == $past(wiper_code_o) - 5'h1;
	endproperty
	property p_no_wrap;
		s_awake |-> !($past(wiper_code_o) == 5'h1f && wiper_code_o == 5'h0)
			&& !($past(wiper_code_o) == 5'h0 && wiper_code_o == 5'h1f);
	endproperty
	property p_top; top_connect_o == !shutdown_o; endproperty
	property p_sd_zero; shutdown_o |-> wiper_code_o == 5'h0; endproperty
	property p_freeze; nv_busy_o && $past(nv_busy_o) |-> $stable(wiper_code_o); endproperty
	property p_write_len; $rose(nv_busy_o) |-> s_write ##[1:12] !nv_busy_o; endproperty
	property p_mode_hold; settle_q == 3'h7 |-> $stable(idle_save_o); endproperty
	property p_block;
		s_awake ##0 !idle_save_o && !store_mode_n_i && !$past(store_mode_n_i, 8) |-> $stable(wiper_code_o);
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap select not one-hot of wiper");
	a_up_db: assert property (p_up_db) else $error("up step without debounced press");
	a_dn_db: assert property (p_dn_db) else $error("down step without debounced press");
	a_one_tap: assert property (p_one_tap) else $error("wiper moved more than one tap");
	a_no_wrap: assert property (p_no_wrap) else $error("wiper wrapped");
	a_top: assert property (p_top) else $error("top tie wrong for shutdown state");
	a_sd_zero: assert property (p_sd_zero) else $error("shutdown wiper not zero");
	a_freeze: assert property (p_freeze) else $error("wiper moved during write");
	a_write_len: assert property (p_write_len) else $error("write length wrong");
	a_mode_hold: assert property (p_mode_hold) else $error("store mode changed");
	a_block: assert property (p_block) else $error("step while mode pin low");
endmodule // pbw_wiper_ctrl_sva
bind pbw_wiper_ctrl pbw_wiper_ctrl_sva #(.TICK_CYC(TICK_CYC)) sva_inst (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .step_up_n_i(step_up_n_i), .step_down_n_i(step_down_n_i),
	.store_mode_n_i(store_mode_n_i), .wiper_code_o(wiper_code_o), .tap_sel_o(tap_sel_o),
	.top_connect_o(top_connect_o), .shutdown_o(shutdown_o), .idle_save_o(idle_save_o),
	.nv_busy_o(nv_busy_o));

// >>> test_pbw_wiper_ctrl.sv
`timescale 1ns/1ps
module test_pbw_wiper_ctrl;
	localparam int MS = 10;
	reg        ref_clk_i;
	reg        rst_i = 1'b1;
	reg        up_r = 1'b0;
	reg        dn_r = 1'b0;
	reg        st_r = 1'b0;
	wire       up_n, dn_n, st_n, top, sd, idle, busy;
	wire [4:0]  wiper;
	wire [31:0] taps;
	int         n_errors = 0;
	int         num_checks = 0;
	bit         row_up[5] = '{1, 1, 0, 1, 0};
	int         row_ms[5] = '{5, 20, 20, 300, 20};
	logic [4:0] row_exp[5] = '{5'h10, 5'h11, 5'h10, 5'h12, 5'h11};
	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	pbw_button_model pbw_button_model_inst (.up_press_i(up_r), .dn_press_i(dn_r), .store_press_i(st_r),
		.step_up_n_o(up_n), .step_down_n_o(dn_n), .store_mode_n_o(st_n));
	// one ms is 10 cycles so the long holds stay short in simulation
	pbw_wiper_ctrl #(.TICK_CYC(10), .NV_WR_CYC(16)) pbw_wiper_ctrl_inst (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .step_up_n_i(up_n), .step_down_n_i(dn_n), .store_mode_n_i(st_n),
		.wiper_code_o(wiper), .tap_sel_o(taps), .top_connect_o(top), .shutdown_o(sd),
		.idle_save_o(idle), .nv_busy_o(busy));
	task tally_and_finish;
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wait_ms(input int ms);
		repeat (ms * MS) @(posedge ref_clk_i);
		#1;
	endtask
	task press(input bit u, input bit d, input int ms);
		up_r = u;
		dn_r = d;
		wait_ms(ms);
		up_r = 1'b0;
		dn_r = 1'b0;
		wait_ms(5);
	endtask
	task wait_busy(input int lim);
		for (int i = 0; i < lim && busy !== 1'b1; i++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		chk(busy, 1'b1);
		if (busy !== 1'b1)
			tally_and_finish();
		wait_ms(3);
	endtask
	task do_reset(input bit st);
		st_r = st;
		rst_i = 1'b1;
		wait_ms(0);
		repeat (4) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
	endtask
	initial
	begin
		do_reset(1'b0);
		chk(wiper, 5'h10);
		chk(idle, 1'b0);
		for (int r = 0; r < 5; r++)
		begin
			press(row_up[r], !row_up[r], row_ms[r]);
			chk(wiper, row_exp[r]);
		end
		press(1'b1, 1'b0, 1600);
		chk(wiper, 5'h1f);
		chk(taps, 32'h8000_0000);
		st_r = 1'b1;
		wait_ms(20);
		st_r = 1'b0;
		wait_busy(400);
		st_r = 1'b1;
		wait_ms(20);
		press(1'b0, 1'b1, 20);
		chk(wiper, 5'h1f);
		st_r = 1'b0;
		wait_busy(400);
		up_r = 1'b1;
		wait_ms(40);
		dn_r = 1'b1;
		wait_ms(2100);
		press(1'b0, 1'b0, 0);
		chk(wiper, 5'h1f);
		chk(sd, 1'b0);
		press(1'b1, 1'b1, 2100);
		chk(sd, 1'b1);
		chk(top, 1'b0);
		chk(wiper, 5'h0);
		press(1'b0, 1'b1, 20);
		chk(sd, 1'b0);
		chk(wiper, 5'h1f);
		do_reset(1'b1);
		st_r = 1'b0;
		chk(idle, 1'b1);
		chk(wiper, 5'h1f);
		press(1'b0, 1'b1, 20);
		chk(wiper, 5'h1e);
		wait_busy(22000);
		tally_and_finish();
	end
endmodule // test_pbw_wiper_ctrl
